// ==== design/srp_pkg.sv ====
// Shared constants and types for the synthesizer register program sequencer
package srp_pkg;
    localparam int WORD_W = 32;
    localparam int CODE_W = 4;
    // Register select codes
    localparam logic [3:0] SEL_INT = 4'h0;
    localparam logic [3:0] SEL_FRAC = 4'h1;
    localparam logic [3:0] SEL_MOD = 4'h2;
    localparam logic [3:0] SEL_REF = 4'h4;
    localparam logic [3:0] SEL_BAND = 4'h9;
    localparam logic [3:0] SEL_ADC = 4'ha;
    localparam logic [3:0] SEL_FIXED = 4'hb;
    localparam logic [3:0] SEL_RESYNC = 4'hc;
    // Field positions and widths
    localparam int INT_LSB = 4;
    localparam int INT_W = 16;
    localparam int AUTOCAL_BIT = 21;
    localparam int PRIMARY_FRACTION_LSB = 4;
    localparam int PRIMARY_FRACTION_W = 24;
    localparam int AUX_MODULUS_LSB = 4;
    localparam int AUX_FRACTION_LSB = 18;
    localparam int AUX_W = 14;
    localparam int CNTRST_BIT = 4;
    localparam int RCNT_LSB = 15;
    localparam int RCNT_W = 10;
    localparam int HALVE_BIT = 25;
    localparam int DOUBLER_BIT = 26;
    localparam int SETTLE_LSB = 4;
    localparam int SETTLE_W = 5;
    localparam int BANDTO_LSB = 14;
    localparam int BANDTO_W = 10;
    localparam int ADCPWR_BIT = 4;
    localparam int CONVWR_BIT = 5;
    localparam int ADCDIV_LSB = 6;
    localparam int ADCDIV_W = 8;
    localparam int RESYNC_LSB = 16;
    localparam int RESYNC_W = 16;
    localparam int PFDDIV_W = RCNT_W + 1;
    // Reset values: reference counter reads as one until programmed
    localparam logic [31:0] REF_RESET = 32'h0000_8004;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    typedef struct packed {
        logic [INT_W-1:0] intValue;
        logic [PRIMARY_FRACTION_W-1:0] primaryFraction;
        logic [AUX_W-1:0] auxFraction;
        logic [AUX_W-1:0] auxModulus;
    } srp_freq_t;

    typedef struct packed {
        logic [RCNT_W-1:0] refCount;
        logic doubler;
        logic halve;
    } srp_ref_t;

    typedef struct packed {
        logic [2:0] sckSync;
        logic [1:0] sdiSync;
        logic [2:0] leSync;
        logic [31:0] shiftWord;
        logic [31:0] wordInt;
        logic [31:0] wordFrac;
        logic [31:0] wordMod;
        logic [31:0] wordRef;
        logic [31:0] wordBand;
        logic [31:0] wordAdc;
        logic [31:0] wordFixed;
        logic [31:0] wordResync;
        logic refWritten;
        srp_freq_t freq;
        logic freqUpd;
        logic autoCal;
        logic adcStart;
        logic [RESYNC_W-1:0] resyncCnt;
        logic resyncArmed;
        logic resyncFire;
    } srp_state_t;
endpackage

// ==== design/srp_tick_div.sv ====
// Tick divider: one output tick for every divisor input ticks
`timescale 1ns/1ps
module srp_tick_div #(
    parameter int W = 8
) (
    input wire logic clk, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic tickIn, // Input tick, one cycle
    input wire logic [W-1:0] divisor, // Zero and one both pass every tick
    output logic tickOut // Divided tick, registered
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic out;
    } srp_div_state_t;

    srp_div_state_t q, nxt;

    always_comb begin
        nxt = q;
        nxt.out = 1'b0;
        if (tickIn) begin
            if (q.cnt + W'(1) >= divisor) begin
                nxt.cnt = '0;
                nxt.out = 1'b1;
            end else begin
                nxt.cnt = q.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= nxt;
        end
    end

    assign tickOut = q.out;

    tick_cause_a: assert property (@(posedge clk) disable iff (rst)
        tickOut |-> $past(tickIn))
        else $error("divided tick without input tick");
endmodule // srp_tick_div

// ==== design/srp_sequencer.sv ====
// Serial-loaded configuration registers and derived timing of the synthesizer
// Notes on behaviour
// - A word whose select code is 1010 lands in the ADC calibration register.
// - ADC clock is comparison-rate tick divided by the ADC divisor field.
// - Until programmed, the reference division factor behaves as one.
// - With convert-on-write set, each ADC register write starts one conversion.
// - ADC power bit powers the temperature ADC.
// - A word whose select code is 1100 lands in the resync timer register.
// - Resync fires after counting resync timeout comparison ticks.
// - Only a register 0 write applies a new frequency.
// - Aux modulus and aux fraction in register 2, primary fraction in 1, integer in 0.
// - Output frequency follows integer, fractions and fixed 24-bit modulus.
// - Comparison rate is reference over R times halve; the doubler is only reported.
// - Band-select timeout comes from register 9 bits 23:14.
`timescale 1ns/1ps
module srp_sequencer (
    input wire logic clk, // 10 MHz system clock
    input wire logic rst, // Async reset, active high
    input wire logic sclkPin, // Serial clock pin
    input wire logic sdataPin, // Serial data pin
    input wire logic loadStrobePin, // Load strobe pin, rising edge latches
    input wire logic refTick, // Reference input tick, one cycle
    output srp_pkg::srp_freq_t freqCfg, // Applied frequency fields
    output logic freqUpdate, // Pulse when a new frequency applies
    output logic autoCalStart, // Pulse when register 0 asks autocal
    output srp_pkg::srp_ref_t refCfg, // Reference path settings
    output logic counterReset, // Counter reset level
    output logic pfdTick, // Comparison-rate tick
    output logic adcClkTick, // ADC clock tick
    output logic adcStart, // Pulse starting one conversion
    output logic adcPowerOn, // Temperature ADC power level
    output logic [9:0] bandSelectTimeout, // Band-select timeout value
    output logic [4:0] lockSettleCount, // Lock-settle count value
    output logic [15:0] resyncTimeout, // Resync timeout value
    output logic resyncFire // Pulse when phase resync triggers
);
    import srp_pkg::*;

    srp_state_t q, nxt;
    logic sckRise;
    logic loadPulse;
    logic [3:0] loadCode;
    logic [PFDDIV_W-1:0] pfdDivisor;

    // Edges look only at the second and third stages
    assign sckRise = q.sckSync[1] & ~q.sckSync[2];
    assign loadPulse = q.leSync[1] & ~q.leSync[2];
    assign loadCode = q.shiftWord[CODE_W-1:0];

    always_comb begin
        nxt = q;
        nxt.sckSync = {q.sckSync[1:0], sclkPin};
        nxt.sdiSync = {q.sdiSync[0], sdataPin};
        nxt.leSync = {q.leSync[1:0], loadStrobePin};
        nxt.freqUpd = 1'b0;
        nxt.autoCal = 1'b0;
        nxt.adcStart = 1'b0;
        nxt.resyncFire = 1'b0;
        if (sckRise) begin
            nxt.shiftWord = {q.shiftWord[30:0], q.sdiSync[1]};
        end
        if (pfdTick && q.resyncArmed) begin
            if (q.resyncCnt <= 16'h0001) begin
                nxt.resyncFire = 1'b1;
                nxt.resyncArmed = 1'b0;
            end else begin
                nxt.resyncCnt = q.resyncCnt - 16'h0001;
            end
        end
        if (loadPulse) begin
            case (loadCode)
                SEL_INT: begin
                    nxt.wordInt = q.shiftWord;
                    // Buffered fraction and modulus apply only here
                    nxt.freq.intValue = q.shiftWord[INT_LSB +: INT_W];
                    nxt.freq.primaryFraction =
                        q.wordFrac[PRIMARY_FRACTION_LSB +: PRIMARY_FRACTION_W];
                    nxt.freq.auxFraction = q.wordMod[AUX_FRACTION_LSB +: AUX_W];
                    nxt.freq.auxModulus = q.wordMod[AUX_MODULUS_LSB +: AUX_W];
                    nxt.freqUpd = 1'b1;
                    nxt.autoCal = q.shiftWord[AUTOCAL_BIT];
                    nxt.resyncCnt = q.wordResync[RESYNC_LSB +: RESYNC_W];
                    nxt.resyncArmed = 1'b1;
                end
                SEL_FRAC: begin
                    nxt.wordFrac = q.shiftWord;
                end
                SEL_MOD: begin
                    nxt.wordMod = q.shiftWord;
                end
                SEL_REF: begin
                    nxt.wordRef = q.shiftWord;
                    nxt.refWritten = 1'b1;
                end
                SEL_BAND: begin
                    nxt.wordBand = q.shiftWord;
                end
                SEL_ADC: begin
                    nxt.wordAdc = q.shiftWord;
                    nxt.adcStart = q.shiftWord[CONVWR_BIT];
                end
                SEL_FIXED: begin
                    nxt.wordFixed = q.shiftWord;
                end
                SEL_RESYNC: begin
                    nxt.wordResync = q.shiftWord;
                end
                default: begin
                    nxt.wordFixed = q.wordFixed;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.wordRef <= REF_RESET;
        end else begin
            q <= nxt;
        end
    end

    // Doubler has no digital effect here; it is reported for the analog path
    assign refCfg.refCount = q.wordRef[RCNT_LSB +: RCNT_W];
    assign refCfg.doubler = q.wordRef[DOUBLER_BIT];
    assign refCfg.halve = q.wordRef[HALVE_BIT];
    assign pfdDivisor = refCfg.halve ? {refCfg.refCount, 1'b0}
                                     : {1'b0, refCfg.refCount};

    srp_tick_div #(
        .W(PFDDIV_W)
    ) uPfdDiv (
        .clk(clk),
        .rst(rst),
        .tickIn(refTick),
        .divisor(pfdDivisor),
        .tickOut(pfdTick)
    );

    srp_tick_div #(
        .W(ADCDIV_W)
    ) uAdcDiv (
        .clk(clk),
        .rst(rst),
        .tickIn(pfdTick),
        .divisor(q.wordAdc[ADCDIV_LSB +: ADCDIV_W]),
        .tickOut(adcClkTick)
    );

    assign freqCfg = q.freq;
    assign freqUpdate = q.freqUpd;
    assign autoCalStart = q.autoCal;
    assign counterReset = q.wordRef[CNTRST_BIT];
    assign adcStart = q.adcStart;
    assign adcPowerOn = q.wordAdc[ADCPWR_BIT];
    assign bandSelectTimeout = q.wordBand[BANDTO_LSB +: BANDTO_W];
    assign lockSettleCount = q.wordBand[SETTLE_LSB +: SETTLE_W];
    assign resyncTimeout = q.wordResync[RESYNC_LSB +: RESYNC_W];
    assign resyncFire = q.resyncFire;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence reg0Load;
        loadPulse && loadCode == SEL_INT;
    endsequence

    sequence adcLoad;
        loadPulse && loadCode == SEL_ADC;
    endsequence

    adc_route_a: assert property (adcLoad |=>
        q.wordAdc == $past(q.shiftWord))
        else $error("ADC word not stored on select 1010");
    resync_route_a: assert property (
        loadPulse && loadCode == SEL_RESYNC |=>
        resyncTimeout == $past(q.shiftWord[31:16]))
        else $error("resync word not stored on select 1100");
    conv_start_a: assert property (adcStart ==
        $past(loadPulse && loadCode == SEL_ADC && q.shiftWord[5]))
        else $error("conversion start mismatch");
    adc_power_a: assert property (adcLoad |=>
        adcPowerOn == $past(q.shiftWord[4]))
        else $error("ADC power bit not followed");
    r_default_a: assert property (!q.refWritten |->
        pfdDivisor == 11'h001)
        else $error("reference factor not one before programming");
    freq_hold_a: assert property (!$past(loadPulse && loadCode == 4'h0)
        |-> $stable(freqCfg) && !freqUpdate)
        else $error("frequency changed without register 0 write");
    freq_apply_a: assert property (reg0Load |=>
        freqUpdate && freqCfg.intValue == $past(q.shiftWord[19:4])
        && freqCfg.primaryFraction == $past(q.wordFrac[27:4]))
        else $error("register 0 write did not apply fields");
    resync_fire_a: assert property (resyncFire |->
        $past(pfdTick && q.resyncArmed && q.resyncCnt <= 16'h0001))
        else $error("resync fired without timeout");
    band_field_a: assert property (
        loadPulse && loadCode == SEL_BAND |=>
        bandSelectTimeout == $past(q.shiftWord[23:14]))
        else $error("band timeout field wrong");
    adc_tick_a: assert property (adcClkTick |-> $past(pfdTick))
        else $error("ADC tick without comparison tick");
endmodule // srp_sequencer

// ==== testbench/srp_host_model.sv ====
// Host-side model that shifts configuration words onto the serial pins
`timescale 1ns/1ps
module srp_host_model (
    input wire logic clk, // System clock
    output logic sclkPin, // Serial clock, still outside frames
    output logic sdataPin, // Serial data
    output logic loadStrobePin // Load strobe
);
    initial begin
        sclkPin = 1'b0;
        sdataPin = 1'b0;
        loadStrobePin = 1'b0;
    end
    // Four clk cycles high and five low per period clear the design's three-flop clock and strobe syncs
    task automatic sendWord(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            @(negedge clk) sdataPin = w[i];
            repeat (4) @(negedge clk);
            sclkPin = 1'b1;
            repeat (4) @(negedge clk);
            sclkPin = 1'b0;
        end
        // Released data line shows a changed level, not the last bit
        @(negedge clk) sdataPin = ~w[0];
        repeat (3) @(negedge clk);
        loadStrobePin = 1'b1;
        repeat (4) @(negedge clk);
        loadStrobePin = 1'b0;
    endtask
endmodule // srp_host_model

// ==== testbench/tb.sv ====
// Self-checking bench for the configuration sequencer
`timescale 1ns/1ps
module tb;
    import srp_pkg::*;
    logic clk, rst, sclkPin, sdataPin, loadStrobePin;
    logic refTick = 1'b0;
    srp_freq_t freqCfg, expF;
    srp_ref_t refCfg;
    logic freqUpdate, autoCalStart, counterReset, pfdTick, adcClkTick;
    logic adcStart, adcPowerOn, resyncFire;
    logic [9:0] bandSelectTimeout, bt;
    logic [4:0] lockSettleCount, ls;
    logic [15:0] resyncTimeout, iv, rt;
    logic [23:0] f1;
    logic [13:0] f2, m2;
    logic [7:0] dv;
    logic [31:0] r;
    int seed = 32'h160c;
    int nErrors = 0, checksDone = 0, a, b, c, t;
    int nRef = 0, nPfd = 0, nAdcClk = 0, nAdcSt = 0, nUpd = 0, nCal = 0, nRes = 0;

    srp_sequencer dut_u (.clk(clk), .rst(rst), .sclkPin(sclkPin),
        .sdataPin(sdataPin), .loadStrobePin(loadStrobePin),
        .refTick(refTick), .freqCfg(freqCfg), .freqUpdate(freqUpdate),
        .autoCalStart(autoCalStart), .refCfg(refCfg),
        .counterReset(counterReset), .pfdTick(pfdTick),
        .adcClkTick(adcClkTick), .adcStart(adcStart),
        .adcPowerOn(adcPowerOn), .bandSelectTimeout(bandSelectTimeout),
        .lockSettleCount(lockSettleCount), .resyncTimeout(resyncTimeout),
        .resyncFire(resyncFire));
    srp_host_model host_u (.clk(clk), .sclkPin(sclkPin),
        .sdataPin(sdataPin), .loadStrobePin(loadStrobePin));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Reference ticks are random but never back to back
    always @(negedge clk) refTick <= !refTick && ($random(seed) & 1) == 1;
    always @(posedge clk) begin
        nRef += refTick;
        nPfd += pfdTick;
        nAdcClk += adcClkTick;
        nAdcSt += adcStart;
        nUpd += freqUpdate;
        nCal += autoCalStart;
        nRes += resyncFire;
    end

    task automatic chk(input logic [67:0] got, exp, input string what);
        checksDone++;
        if (got !== exp) begin
            nErrors++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask
    task automatic chkIn(input int got, lo, hi, input string what);
        chk({67'h0, got >= lo && got <= hi}, 68'h1, what);
    endtask
    task automatic send(input logic [31:0] w);
        host_u.sendWord(w);
        repeat (3) @(negedge clk);
    endtask
    task automatic loadFrac();
        r = $random(seed);
        iv = r[15:0];
        f2 = r[29:16];
        r = $random(seed);
        f1 = r[23:0];
        m2 = {r[31:19], 1'b1};
        send({f2, m2, 4'h2});
        send({4'h0, f1, 4'h1});
    endtask
    // Waits out 17 ADC clocks, checking the divide ratio on the way
    // Own snapshots, so the caller's pulse counters survive the wait
    task automatic waitAdc();
        int a0, b0;
        a0 = nAdcClk;
        b0 = nPfd;
        for (t = 0; t < 5000 && nAdcClk - a0 < 17; t++) @(negedge clk);
        chkIn(nPfd - b0, 16 * dv, 17 * dv + 1, "ADC clock ratio");
        chkIn(t, 0, 4999, "ADC wait bound");
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checksDone, nErrors);
        if (nErrors == 0 && checksDone > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        chk(refCfg, 12'h004, "reset reference");
        chk(freqCfg, 68'h0, "reset frequency");
        a = nRef;
        b = nPfd;
        repeat (200) @(negedge clk);
        chkIn(nPfd - b, nRef - a - 1, nRef - a + 1, "unit divide");
        $display("test reset done");
        r = $random(seed);
        rt = 16'd30 + r[3:0];
        dv = 8'd3;
        bt = r[13:4];
        ls = r[18:14];
        send({rt, 5'h0, 1'b1, 5'h0, 1'b1, 4'hc});
        chk(resyncTimeout, rt, "resync timeout");
        send(32'h0061300b);
        a = nAdcSt;
        send({8'h0, 2'b11, 8'h0, dv, 1'b1, 1'b1, 4'ha});
        chk(adcPowerOn, 1'b1, "ADC power");
        chkIn(nAdcSt - a, 1, 1, "conversion start");
        send({8'h0, bt, 5'h0, ls, 4'h9});
        chk(bandSelectTimeout, bt, "band timeout");
        chk(lockSettleCount, ls, "settle count");
        send({5'h0, 1'b0, 1'b0, 10'h1, 10'h0, 1'b0, 4'h4});
        loadFrac();
        chk(freqCfg, 68'h0, "buffered fraction");
        waitAdc();
        a = nUpd;
        b = nCal;
        send({10'h0, 1'b1, 1'b0, iv, 4'h0});
        expF = '{iv, f1, f2, m2};
        chk(freqCfg, expF, "frequency fields");
        chkIn(nUpd - a, 1, 1, "update pulse");
        chkIn(nCal - b, 1, 1, "autocal pulse");
        a = nPfd;
        c = nRes;
        for (t = 0; t < 3000 && nRes == c; t++) @(negedge clk);
        chkIn(nPfd - a, rt - 3, rt + 1, "resync delay");
        chkIn(t, 0, 2999, "resync wait bound");
        $display("test power-up done");
        a = nAdcSt;
        send({8'h0, 2'b11, 8'h0, dv, 1'b0, 1'b1, 4'ha});
        chkIn(nAdcSt - a, 0, 0, "no conversion");
        send({5'h0, 1'b1, 1'b1, 10'h2, 10'h0, 1'b1, 4'h4});
        chk(refCfg, {10'h2, 1'b1, 1'b1}, "reference fields");
        chk(counterReset, 1'b1, "counter reset on");
        a = nRef;
        b = nPfd;
        repeat (400) @(negedge clk);
        chkIn(4 * (nPfd - b), nRef - a - 4, nRef - a + 4, "halved rate");
        a = nUpd;
        b = nCal;
        loadFrac();
        send({28'hfffffff, 4'h5});
        chk(freqCfg, expF, "held frequency");
        chkIn(nUpd - a, 0, 0, "no early update");
        send({10'h0, 1'b0, 1'b0, iv, 4'h0});
        expF = '{iv, f1, f2, m2};
        chk(freqCfg, expF, "new frequency");
        chkIn(nCal - b, 0, 0, "autocal off");
        send({5'h0, 1'b1, 1'b1, 10'h2, 10'h0, 1'b0, 4'h4});
        chk(counterReset, 1'b0, "counter reset off");
        waitAdc();
        send({10'h0, 1'b1, 1'b0, iv, 4'h0});
        chkIn(nCal - b, 1, 1, "autocal on");
        chkIn(nUpd - a, 2, 2, "update count");
        $display("test update done");
        send({5'h0, 1'b0, 1'b0, 10'h1, 10'h0, 1'b0, 4'h4});
        chk(refCfg, 12'h004, "retarget reference");
        loadFrac();
        send({10'h0, 1'b0, 1'b0, iv, 4'h0});
        expF = '{iv, f1, f2, m2};
        chk(freqCfg, expF, "retarget frequency");
        chkIn(nCal - b, 1, 1, "retarget autocal off");
        chkIn(nUpd - a, 3, 3, "retarget update");
        $display("test retarget done");
        conclude();
    end
endmodule // tb
